// file: common/uew_pkg.sv
// Package with register map, field positions and timing constants of the serial channel.
package uew_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  // Mode register fields.
  localparam int MODE_SC_LO = 0;
  localparam int MODE_SM_LO = 2;
  localparam int MODE_WU    = 4;
  localparam int MODE_RXE   = 5;
  localparam int MODE_TB8   = 7;
  localparam logic [1:0] SM_8BIT = 2'h2;
  localparam logic [1:0] SM_9BIT = 2'h3;
  localparam logic [1:0] SC_SYS  = 2'h2;
  // Control register fields.
  localparam int CTRL_PERR = 0;
  localparam int CTRL_FERR = 1;
  localparam int CTRL_OERR = 2;
  localparam int CTRL_PE   = 5;
  localparam int CTRL_EVEN = 6;
  localparam int CTRL_RB8  = 7;
  localparam int CTRL_RXF  = 8;
  localparam int CTRL_TXB  = 9;
  // Reset values.
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0004;
  // Oversampling per bit and the mid-bit sample point.
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID  = 4'h7;
  // AXI responses.
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// file: hw/uew_uart.sv
// Eight and nine bit asynchronous serial channel with wakeup, behind AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - Mode field 10 selects 8-bit frames.
// - 8-bit parity only when parity enabled.
// - Parity polarity bit set means even.
// - Mode field 11 selects 9-bit frames.
// - 9-bit frames never carry parity.
// - Transmit ninth bit from mode register.
// - Received ninth bit into control register.
// - Wakeup bit active in 9-bit mode.
// - Wakeup: receive event only when ninth one.
// - Woken-out slaves ignore ninth-zero frames.
// - Selected slave may answer the master.
// - Clock select 10 uses system clock.
// - No reception while receive enable clear.
module uew_uart
  import uew_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address, data and response.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line, open-drain capable transmit pin.
  input  wire logic        rx_pin,
  output logic             tx_out,
  output logic             tx_oe,
  input  wire logic        tx_open_drain,
  // Event pulses.
  output logic             receive_interrupt,
  output logic             transmit_interrupt
);

  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01, TX_STOP = 2'b11} uew_tx_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SHIFT = 2'b01, RX_STOP = 2'b11} uew_rx_t;

  typedef struct packed {
    logic        awdone;
    logic        wdone;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  mode;
    logic [7:0]  ctrl;
    logic        rxf;
    logic [15:0] baud;
    logic [7:0]  rxbuf;
    logic [15:0] bdiv;
    logic        tick;
    uew_tx_t     txs;
    logic [3:0]  txo;
    logic [3:0]  txn;
    logic [9:0]  txsh;
    logic        txd;
    logic        txbusy;
    uew_rx_t     rxs;
    logic [3:0]  rxo;
    logic [3:0]  rxn;
    logic [9:0]  rxsh;
    logic [1:0]  rsync;
    logic        rxi;
    logic        txi;
    logic        oe;
  } uew_state_t;

  uew_state_t s;
  uew_state_t next_s;

  // Number of data-plus-extra bits for the active format.
  function automatic logic [3:0] frame_bits(input logic [7:0] m, input logic [7:0] c);
    if (m[MODE_SM_LO +: 2] == SM_9BIT) begin
      frame_bits = 4'h9;
    end else if (c[CTRL_PE]) begin
      frame_bits = 4'h9;
    end else begin
      frame_bits = 4'h8;
    end
  endfunction

  // Parity bit for a byte: even polarity makes the total count of ones even.
  function automatic logic par_bit(input logic [7:0] d, input logic even);
    par_bit = even ? ^d : ~^d;
  endfunction

  // Combinational next-state logic for bus, baud tick, transmitter and receiver.
  always_comb begin
    logic        wr;
    logic        rd;
    logic [31:0] rv;
    logic        act;
    logic        ninth;
    logic        rbit;
    logic [7:0]  d;
    logic        n9;
    logic        nine;
    logic        take;
    next_s = s;
    d = 8'h00;
    n9 = 1'b0;
    nine = 1'b0;
    take = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    rv = 32'h0000_0000;
    act = (s.mode[MODE_SM_LO +: 2] == SM_8BIT) || (s.mode[MODE_SM_LO +: 2] == SM_9BIT);
    ninth = 1'b0;
    rbit = s.rsync[1];
    next_s.rsync = {s.rsync[0], rx_pin};
    next_s.rxi = 1'b0;
    next_s.txi = 1'b0;

    // Write channel: address and data taken in either order, response after both.
    if (s_axi_awvalid && !s.awdone) begin
      next_s.awdone = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.wdone) begin
      next_s.wdone = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.awdone && s.wdone && !s.bvalid) begin
      wr = 1'b1;
      next_s.awdone = 1'b0;
      next_s.wdone = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OK;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register writes; the data write starts a frame when the transmitter is free.
    if (wr) begin
      unique case (s.awaddr)
        OFS_MODE: if (s.wstrb[0]) next_s.mode = s.wdata[7:0];
        OFS_CTRL: if (s.wstrb[0]) next_s.ctrl[6:5] = s.wdata[6:5];
        OFS_BAUD: begin
          if (s.wstrb[0]) next_s.baud[7:0] = s.wdata[7:0];
          if (s.wstrb[1]) next_s.baud[15:8] = s.wdata[15:8];
        end
        OFS_DATA: begin
          if (s.wstrb[0] && !s.txbusy && act) begin
            // Ninth bit is the stored transmit ninth bit or the parity bit.
            if (s.mode[MODE_SM_LO +: 2] == SM_9BIT) begin
              ninth = s.mode[MODE_TB8];
            end else begin
              ninth = par_bit(s.wdata[7:0], s.ctrl[CTRL_EVEN]);
            end
            next_s.txsh = {ninth, s.wdata[7:0], 1'b0};
            next_s.txbusy = 1'b1;
          end
        end
        default: next_s.bresp = RESP_ERR;
      endcase
    end

    // Read channel; reading the buffer releases the receive-full flag.
    if (s_axi_arvalid && !s.rvalid) begin
      rd = 1'b1;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OK;
      unique case (s_axi_araddr)
        OFS_MODE: rv = {24'h000000, s.mode};
        OFS_CTRL: rv = {22'h000000, s.txbusy, s.rxf, s.ctrl};
        OFS_DATA: rv = {24'h000000, s.rxbuf};
        OFS_BAUD: rv = {16'h0000, s.baud};
        default:  next_s.rresp = RESP_ERR;
      endcase
      next_s.rdata = rv;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Oversampling tick from the system clock when clock select is 10.
    next_s.tick = 1'b0;
    if (s.mode[MODE_SC_LO +: 2] == SC_SYS) begin
      if (s.bdiv >= s.baud) begin
        next_s.bdiv = 16'h0000;
        next_s.tick = 1'b1;
      end else begin
        next_s.bdiv = s.bdiv + 16'h0001;
      end
    end else begin
      next_s.bdiv = 16'h0000;
    end

    // Transmitter: start, bits LSB first, ninth or parity, one stop bit.
    unique case (s.txs)
      TX_IDLE: begin
        next_s.txd = 1'b1;
        if (s.txbusy && s.tick) begin
          next_s.txs = TX_SHIFT;
          next_s.txo = 4'h0;
          next_s.txn = 4'h0;
          next_s.txd = s.txsh[0];
        end
      end
      TX_SHIFT: if (s.tick) begin
        next_s.txo = s.txo + 4'h1;
        if (s.txo == OVS_LAST) begin
          next_s.txsh = {1'b1, s.txsh[9:1]};
          if (s.txn == frame_bits(s.mode, s.ctrl)) begin
            next_s.txs = TX_STOP;
            next_s.txd = 1'b1;
          end else begin
            next_s.txn = s.txn + 4'h1;
            next_s.txd = s.txsh[1];
          end
        end
      end
      TX_STOP: if (s.tick) begin
        next_s.txo = s.txo + 4'h1;
        if (s.txo == OVS_LAST) begin
          next_s.txs = TX_IDLE;
          next_s.txbusy = 1'b0;
          next_s.txi = 1'b1;
        end
      end
      default: next_s.txs = TX_IDLE;
    endcase
    // Drive enable is registered with the level; open drain releases the high level.
    next_s.oe = !tx_open_drain || !next_s.txd;

    // Receiver: mid-bit sampling, gated by receive enable.
    unique case (s.rxs)
      RX_IDLE: begin
        if (s.tick && !rbit && s.mode[MODE_RXE] && act) begin
          next_s.rxs = RX_SHIFT;
          next_s.rxo = 4'h0;
          next_s.rxn = 4'h0;
        end
      end
      RX_SHIFT: if (s.tick) begin
        next_s.rxo = s.rxo + 4'h1;
        if (s.rxo == OVS_MID) begin
          if (s.rxn == 4'h0 && rbit) begin
            next_s.rxs = RX_IDLE; // False start glitch.
          end else begin
            next_s.rxsh = {rbit, s.rxsh[9:1]};
            next_s.rxn = s.rxn + 4'h1;
            if (s.rxn == frame_bits(s.mode, s.ctrl)) begin
              next_s.rxs = RX_STOP;
            end
          end
        end
      end
      RX_STOP: if (s.tick) begin
        next_s.rxo = s.rxo + 4'h1;
        if (s.rxo == OVS_MID) begin
          next_s.rxs = RX_IDLE;
          begin
            nine = (s.mode[MODE_SM_LO +: 2] == SM_9BIT);
            d  = nine || s.ctrl[CTRL_PE] ? s.rxsh[8:1] : s.rxsh[9:2];
            n9 = s.rxsh[9];
            // Wakeup suppresses ninth-zero frames entirely.
            take = !(nine && s.mode[MODE_WU] && !n9);
            if (take) begin
              next_s.rxbuf = d;
              next_s.ctrl[CTRL_FERR] = !rbit;
              next_s.ctrl[CTRL_OERR] = s.rxf;
              next_s.ctrl[CTRL_PERR] = !nine && s.ctrl[CTRL_PE] &&
                                       (n9 != par_bit(d, s.ctrl[CTRL_EVEN]));
              if (nine) begin
                next_s.ctrl[CTRL_RB8] = n9;
              end
              next_s.rxf = 1'b1;
              next_s.rxi = 1'b1;
            end
          end
        end
      end
      default: next_s.rxs = RX_IDLE;
    endcase

    // Buffer read clears full; a frame landing in the same cycle wins.
    if (rd && s_axi_araddr == OFS_DATA && !next_s.rxi) begin
      next_s.rxf = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.mode <= MODE_RST;
      s.ctrl <= CTRL_RST;
      s.baud <= BAUD_RST;
      s.txd <= 1'b1;
      s.oe <= 1'b1;
      s.rsync <= 2'b11;
      s.txs <= TX_IDLE;
      s.rxs <= RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register; open drain only drives low, except from reset, which loads drive enable and level high.
  always_comb begin
    s_axi_awready = !s.awdone;
    s_axi_wready = !s.wdone;
    s_axi_bvalid = s.bvalid;
    s_axi_bresp = s.bresp;
    s_axi_arready = !s.rvalid;
    s_axi_rvalid = s.rvalid;
    s_axi_rresp = s.rresp;
    s_axi_rdata = s.rdata;
    tx_out = s.txd;
    tx_oe = s.oe;
    receive_interrupt = s.rxi;
    transmit_interrupt = s.txi;
  end

endmodule

// file: dv/uew_uart_assertions.sv
// Port-level checks of the serial channel, bound into its top module.
`timescale 1ns/1ps
module uew_uart_assertions (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Serial pin and events.
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic tx_open_drain,
  input wire logic receive_interrupt,
  input wire logic transmit_interrupt
);
  // All checks share one clock and sleep while reset is low.
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_IDLE_AFTER_RESET: assert property ($rose(aresetn) |-> tx_out && !s_axi_bvalid)
    else $error("line or bus not idle after reset");
  AST_PUSH_PULL: assert property (!tx_open_drain && $stable(tx_open_drain) |-> tx_oe)
    else $error("push-pull pin not driven");
  AST_OPEN_DRAIN: assert property (tx_open_drain && $stable(tx_open_drain) |-> tx_oe == !tx_out)
    else $error("open-drain pin drives a high level");
  AST_STOP_HIGH: assert property (transmit_interrupt |-> tx_out)
    else $error("frame ends without a high stop level");
  AST_TX_PULSE: assert property (transmit_interrupt |=> !transmit_interrupt [*8])
    else $error("transmit event is not a single pulse");
  AST_RX_PULSE: assert property (receive_interrupt |=> !receive_interrupt [*8])
    else $error("receive event is not a single pulse");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
endmodule
bind uew_uart uew_uart_assertions u_chk (.*);

// file: dv/uew_line_model.sv
// Far-end controller: drives our receive pin and captures frames from our line.
`timescale 1ns/1ps
module uew_line_model #(
  parameter int BIT_CLKS = 16
) (
  // Bench clock.
  input  wire logic aclk,
  // Shared line levels.
  input  wire logic line_in,
  output logic      line_out
);
  int rx_q[$];
  int v;
  initial line_out = 1'b1;
  // Start bit, then ten bits least significant first, then idle high.
  task automatic send(input int bits);
    for (int i = -1; i < 10; i++) begin
      line_out <= (i < 0) ? 1'b0 : bits[i];
      repeat (BIT_CLKS) @(posedge aclk);
    end
    line_out <= 1'b1;
  endtask
  // Samples each bit at its middle once a start edge is seen.
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge aclk);
    v = 0;
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CLKS) @(posedge aclk);
      v[i] = line_in;
    end
    rx_q.push_back(v);
  end
endmodule

// file: dv/uew_uart_tb.sv
// Self-checking bench for the serial channel with wakeup.
`timescale 1ns/1ps
module uew_uart_tb import uew_pkg::*;;
  localparam int BC = 16;
  logic aclk = 0, aresetn = 0, rx_pin, tx_open_drain = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_out, tx_oe, receive_interrupt, transmit_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int num_errors = 0, check_count = 0, rx_irqs = 0, tx_irqs = 0, d;
  // Shared line has a pull-up, so a released pin reads high.
  wire tx_line = tx_oe ? tx_out : 1'b1;
  uew_uart uut (.*);
  uew_line_model #(.BIT_CLKS(BC)) mdl (.aclk(aclk), .line_in(tx_line), .line_out(rx_pin));
  // Clock and receive and transmit event counters.
  always #10 aclk = ~aclk;
  always @(posedge aclk) if (receive_interrupt === 1'b1) rx_irqs++;
  always @(posedge aclk) if (transmit_interrupt === 1'b1) tx_irqs++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, RESP_OK);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Expected ten bits after the start bit, stop or idle included.
  function automatic int frm(int v, int m9, int pe, int ev, int b8);
    if (m9) return v | (b8 << 8) | 512;
    if (pe) return v | (int'(^v[7:0] ^ !ev) << 8) | 512;
    return v | 768;
  endfunction
  function automatic logic [31:0] md(int m9, int wu, int b8, int receive_enable_bit);
    return {24'h0, b8[0], 1'b0, receive_enable_bit[0], wu[0], m9 ? SM_9BIT : SM_8BIT, SC_SYS};
  endfunction
  task automatic tx_case(int m9, int pe, int ev, int b8);
    int n;
    n = tx_irqs;
    d = $urandom % 256;
    wr(OFS_CTRL, (pe << CTRL_PE) | (ev << CTRL_EVEN));
    wr(OFS_MODE, md(m9, 0, b8, 1));
    wr(OFS_DATA, d);
    while (mdl.rx_q.size() == 0) @(posedge aclk);
    chk(mdl.rx_q.pop_front(), frm(d, m9, pe, ev, b8));
    repeat (BC) @(posedge aclk);
    chk(tx_irqs - n, 1);
  endtask
  task automatic rx_case(int bits, int n_irq, int v);
    int n;
    n = rx_irqs;
    mdl.send(bits);
    repeat (BC) @(posedge aclk);
    chk(rx_irqs - n, n_irq);
    if (n_irq > 0) rd_reg(OFS_DATA);
    if (n_irq > 0) chk(rd[7:0], v);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    void'($urandom(32'h5d5a));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(OFS_MODE);
    chk(rd, MODE_RST);
    rd_reg(OFS_BAUD);
    chk(rd, BAUD_RST);
    rd_reg(8'h10);
    chk(rsp, RESP_ERR);
    wr(OFS_BAUD, 0);
    $display("test registers done");
    for (int i = 0; i < 3; i++) tx_case(0, i > 0, i == 2, 0);
    for (int b = 0; b < 2; b++) tx_case(1, 1, 0, b);
    $display("test transmit done");
    wr(OFS_CTRL, 1 << CTRL_PE);
    wr(OFS_MODE, md(0, 0, 0, 0));
    rx_case(frm(d, 0, 1, 0, 0), 0, 0);
    wr(OFS_MODE, md(0, 0, 0, 1));
    rx_case(frm(d, 0, 1, 0, 0), 1, d);
    mdl.send(frm(d, 0, 1, 1, 0));
    repeat (BC) @(posedge aclk);
    rd_reg(OFS_CTRL);
    chk(rd[CTRL_PERR], 1);
    $display("test receive done");
    wr(OFS_MODE, md(1, 1, 0, 1));
    rx_case(frm(d, 1, 0, 0, 0), 0, 0);
    rx_case(frm(d, 1, 0, 0, 1), 1, d);
    rd_reg(OFS_CTRL);
    chk(rd[CTRL_RB8], 1);
    wr(OFS_MODE, md(1, 0, 0, 1));
    rx_case(frm(d ^ 255, 1, 0, 0, 0), 1, d ^ 255);
    rd_reg(OFS_CTRL);
    chk(rd[CTRL_RB8], 0);
    tx_open_drain <= 1'b1;
    tx_case(1, 0, 0, 0);
    $display("test wakeup done");
    wr(OFS_MODE, md(0, 0, 0, 1) & 32'hfc);
    wr(OFS_DATA, 8'h5a);
    repeat (12 * BC) @(posedge aclk);
    chk(mdl.rx_q.size(), 0);
    $display("test clock select done");
    wrap_up();
  end
  // Watchdog against a hung handshake or a lost frame.
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end
endmodule
